// >>> hdl/rx_digital_gain_and_slicer.sv
// module: receive digital gain, interface gain (slicer) and output framing
// Contract
// - compensation mode: digital gain cancels analog attenuation
// - correction mode: small per-index gain evens steps
// - table entry: attenuator setting plus two gains
// - compensation works under AGC and manual control
// - quantized modes round 22-bit data to 15/16
// - full mode forwards 22-bit data in 32-bit words
// - full word carries change bit and chosen field
// - slicer sits after filtering, on final data
// - slicer gain automatic from level or host set
// - negative interface gain prevents output clipping
// - narrowband quantizer uses positive interface gain
// - unity digital scale keeps full scale at 0 dBFS
// - fast attack cuts interface gain on peaks
// - gain control reset restarts all state machines
// - gain index kept inside min/max limits
// - gain index readable and writable by host
// - narrowband gain 0..18 dB, wideband zero; compensation mode lets both go down to -18 dB
// - interface gain is a shift, 6 dB steps
`timescale 1ns/1ns
module rx_digital_gain_and_slicer
  import rx_gain_pkg::*;
#(
  parameter int IDX_W          = 6,
  parameter int UPDATE_SAMPLES = 64,
  parameter int AVG_SHIFT      = 4
)(
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic [7:0]               regAddr,
  input  wire logic [31:0]              regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic [31:0]                   regRdData,
  input  wire logic                     inValid,
  input  wire logic signed [DATA_W-1:0] inI,
  input  wire logic signed [DATA_W-1:0] inQ,
  input  wire logic                     agcGainDec,
  input  wire logic                     agcGainInc,
  output logic [ATTEN_W-1:0]            attenSetting,
  output logic                          outValid,
  output logic [WORD_W-1:0]             outI,
  output logic [WORD_W-1:0]             outQ
);

  localparam int DEPTH = 1 << IDX_W;
  localparam int CNT_W = $clog2(UPDATE_SAMPLES);
  localparam logic [CNT_W-1:0] UPD_LAST = CNT_W'(UPDATE_SAMPLES - 1);

  if (IDX_W < 2 || IDX_W > 8) $error("IDX_W must be 2..8");
  if (UPDATE_SAMPLES < 2 || (UPDATE_SAMPLES & (UPDATE_SAMPLES - 1)) != 0)
    $error("UPDATE_SAMPLES must be a power of two");

  // ****************************************
  // registers
  // ****************************************
  logic                   compMode_q, compMode_d;
  logic                   agcEn_q, agcEn_d;
  logic                   sliceAuto_q, sliceAuto_d;
  logic                   narrow_q, narrow_d;
  ifmode_type             ifMode_q, ifMode_d;
  field_type              fieldSel_q, fieldSel_d;
  logic [IDX_W-1:0]       idxMin_q, idxMin_d;
  logic [IDX_W-1:0]       idxMax_q, idxMax_d;
  logic [IDX_W-1:0]       gainIdx_q, gainIdx_d;
  logic signed [2:0]      hostSlice_q, hostSlice_d;
  logic [4:0]             target_q, target_d;
  logic [2:0]             papr_q, papr_d;
  logic [IDX_W-1:0]       tblAddr_q, tblAddr_d;
  logic [31:0]            table_q [DEPTH];
  logic [31:0]            table_d [DEPTH];
  logic [31:0]            regRdData_d;
  logic                   gcReset;
  logic                   wrIdx;

  assign gcReset = regWr && regAddr == OFS_CTRL && regWrData[CTRL_RESET];
  assign wrIdx   = regWr && regAddr == OFS_GAIN_IDX;

  always_comb begin
    compMode_d  = compMode_q;
    agcEn_d     = agcEn_q;
    sliceAuto_d = sliceAuto_q;
    narrow_d    = narrow_q;
    ifMode_d    = ifMode_q;
    fieldSel_d  = fieldSel_q;
    idxMin_d    = idxMin_q;
    idxMax_d    = idxMax_q;
    hostSlice_d = hostSlice_q;
    target_d    = target_q;
    papr_d      = papr_q;
    tblAddr_d   = tblAddr_q;
    table_d     = table_q;
    if (regWr) begin
      unique case (regAddr)
        OFS_CTRL: begin
          compMode_d  = regWrData[CTRL_COMP];
          agcEn_d     = regWrData[CTRL_AGC];
          sliceAuto_d = regWrData[CTRL_AUTO];
          narrow_d    = regWrData[CTRL_NARROW];
          ifMode_d    = ifmode_type'(regWrData[CTRL_IFMODE +: 2]);
          fieldSel_d  = field_type'(regWrData[CTRL_FIELD +: 2]);
        end
        OFS_LIMITS: begin
          idxMin_d = regWrData[0 +: IDX_W];
          idxMax_d = regWrData[LIM_MAX_POS +: IDX_W];
        end
        OFS_SLICE: hostSlice_d = regWrData[2:0];
        OFS_TARGET: begin
          target_d = regWrData[4:0];
          papr_d   = regWrData[TGT_PAPR_POS +: 3];
        end
        OFS_TBL_ADDR: tblAddr_d = regWrData[IDX_W-1:0];
        OFS_TBL_DATA: table_d[tblAddr_q] = regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      compMode_q  <= 1'b0;
      agcEn_q     <= 1'b0;
      sliceAuto_q <= 1'b0;
      narrow_q    <= 1'b0;
      ifMode_q    <= IF_FULL;
      fieldSel_q  <= FLD_ZERO;
      idxMin_q    <= '0;
      idxMax_q    <= '1;
      hostSlice_q <= '0;
      target_q    <= TARGET_RST;
      papr_q      <= PAPR_RST;
      tblAddr_q   <= '0;
      table_q     <= '{default: TBL_RST};
    end else begin
      compMode_q  <= compMode_d;
      agcEn_q     <= agcEn_d;
      sliceAuto_q <= sliceAuto_d;
      narrow_q    <= narrow_d;
      ifMode_q    <= ifMode_d;
      fieldSel_q  <= fieldSel_d;
      idxMin_q    <= idxMin_d;
      idxMax_q    <= idxMax_d;
      hostSlice_q <= hostSlice_d;
      target_q    <= target_d;
      papr_q      <= papr_d;
      tblAddr_q   <= tblAddr_d;
      table_q     <= table_d;
    end
  end

  // ****************************************
  // gain index and digital gain stage
  // ****************************************
  logic [31:0]              entry;
  logic [GAIN_W-1:0]        mulSel;
  logic signed [34:0]       prodI, prodQ;
  logic                     dgValid_q, dgValid_d;
  logic signed [DATA_W-1:0] dgI_q, dgI_d, dgQ_q, dgQ_d;
  logic [ATTEN_W-1:0]       atten_d;

  function automatic logic signed [DATA_W-1:0] satData(
    input logic signed [34:0] p);
    logic signed [34:0] s;
    s = p >>> GAIN_FRAC;
    if (s > 35'sh1FFFFF) return 22'sh1FFFFF;
    else if (s < -35'sh200000) return 22'sh200000;
    else return DATA_W'(s);
  endfunction

  always_comb begin
    gainIdx_d = gainIdx_q;
    if (gcReset) gainIdx_d = idxMax_q;
    else if (wrIdx) gainIdx_d = regWrData[IDX_W-1:0];
    else if (agcEn_q && agcGainDec)
      gainIdx_d = (gainIdx_q == '0) ? gainIdx_q : gainIdx_q - 1'b1;
    else if (agcEn_q && agcGainInc)
      gainIdx_d = (gainIdx_q == '1) ? gainIdx_q : gainIdx_q + 1'b1;
    // limits also pull a host-written index back into range
    if (gainIdx_d < idxMin_q) gainIdx_d = idxMin_q;
    if (gainIdx_d > idxMax_q) gainIdx_d = idxMax_q;
  end

  // the table holds both gains so switching mode needs no reload
  always_comb begin
    entry   = table_q[gainIdx_q];
    atten_d = entry[TBL_ATTEN_POS +: ATTEN_W];
    mulSel  = compMode_q ? entry[TBL_COMP_POS +: GAIN_W]
                         : entry[TBL_CORR_POS +: GAIN_W];
    // unity multiplier keeps adc full scale at data full scale
    prodI     = $signed(inI) * $signed({1'b0, mulSel});
    prodQ     = $signed(inQ) * $signed({1'b0, mulSel});
    dgValid_d = inValid;
    dgI_d     = inValid ? satData(prodI) : dgI_q;
    dgQ_d     = inValid ? satData(prodQ) : dgQ_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gainIdx_q    <= '0;
      attenSetting <= '0;
      dgValid_q    <= 1'b0;
      dgI_q        <= '0;
      dgQ_q        <= '0;
    end else begin
      gainIdx_q    <= gainIdx_d;
      attenSetting <= atten_d;
      dgValid_q    <= dgValid_d;
      dgI_q        <= dgI_d;
      dgQ_q        <= dgQ_d;
    end
  end

  // ****************************************
  // interface gain control
  // ****************************************
  logic [MSB_W-1:0]  avgMsb, peakMsb;
  slice_state_type   sliceState_q, sliceState_d;
  logic [CNT_W-1:0]  updCnt_q, updCnt_d;
  logic signed [2:0] sliceGain_q, sliceGain_d;
  logic signed [7:0] want, lo, hi, tgtS, peakLvl;
  logic              updDone;

  // estimate taken on the filtered end of the path, just ahead of the slicer
  rx_level_est #(
    .AVG_SHIFT (AVG_SHIFT)
  ) u_level (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clear    (gcReset),
    .valid    (dgValid_q),
    .dataI    (dgI_q),
    .dataQ    (dgQ_q),
    .avgMsb   (avgMsb),
    .peakMsb  (peakMsb)
  );

  always_comb begin
    sliceState_d = sliceState_q;
    updCnt_d     = updCnt_q;
    updDone      = dgValid_q && updCnt_q == UPD_LAST;
    tgtS         = $signed({3'h0, target_q});
    peakLvl      = $signed({3'h0, peakMsb}) + 8'(sliceGain_q);
    // gain below zero only where compensation can overdrive the port
    lo = compMode_q ? 8'(SLICE_MIN) : 8'sh00;
    hi = (narrow_q && ifMode_q != IF_FULL) ? 8'(SLICE_MAX)
                                           : 8'sh00;
    want = 8'(sliceGain_q);
    if (sliceAuto_q) begin
      if (dgValid_q) updCnt_d = updCnt_q + 1'b1;
      unique case (sliceState_q)
        SL_SETTLE: if (updDone) sliceState_d = SL_TRACK;
        SL_TRACK: if (updDone) begin
          want = tgtS - $signed({5'h0, papr_q})
               - $signed({3'h0, avgMsb});
        end
      endcase
      // tracking is slow; a burst start must not wait a whole period
      if (peakLvl > tgtS) want = tgtS - $signed({3'h0, peakMsb});
    end else begin
      want = 8'(hostSlice_q);
    end
    if (want < lo) want = lo;
    if (want > hi) want = hi;
    sliceGain_d = 3'(want);
    if (gcReset) begin
      sliceState_d = SL_SETTLE;
      updCnt_d     = '0;
      sliceGain_d  = '0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sliceState_q <= SL_SETTLE;
      updCnt_q     <= '0;
      sliceGain_q  <= '0;
    end else begin
      sliceState_q <= sliceState_d;
      updCnt_q     <= updCnt_d;
      sliceGain_q  <= sliceGain_d;
    end
  end

  // ****************************************
  // slicer and output framing
  // ****************************************
  logic signed [15:0]  qI, qQ;
  logic                pend_q, pend_d;
  logic                changed, q15;
  logic [FIELD_W-1:0]  fieldVal;
  logic                outValid_d;
  logic [WORD_W-1:0]   outI_d, outQ_d;

  assign q15 = ifMode_q == IF_Q15;

  rx_slicer u_slice_i (
    .dataIn  (dgI_q),
    .shift   (sliceGain_q),
    .q15     (q15),
    .dataOut (qI)
  );

  rx_slicer u_slice_q (
    .dataIn  (dgQ_q),
    .shift   (sliceGain_q),
    .q15     (q15),
    .dataOut (qQ)
  );

  always_comb begin
    changed = sliceGain_d != sliceGain_q || gainIdx_d != gainIdx_q;
    // a change in the same cycle as the flagged sample stays pending
    pend_d  = (pend_q && !dgValid_q) || changed;
    unique case (fieldSel_q)
      FLD_IFGAIN: fieldVal = FIELD_W'(sliceGain_q);
      FLD_INDEX:  fieldVal = FIELD_W'(gainIdx_q);
      default:    fieldVal = '0;
    endcase
    outValid_d = dgValid_q;
    outI_d     = outI;
    outQ_d     = outQ;
    if (dgValid_q) begin
      if (ifMode_q == IF_FULL) begin
        // full resolution: the host takes the full words unrounded
        outI_d = {fieldVal, pend_q, dgI_q};
        outQ_d = {fieldVal, pend_q, dgQ_q};
      end else begin
        outI_d = WORD_W'(qI);
        outQ_d = WORD_W'(qQ);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q   <= 1'b0;
      outValid <= 1'b0;
      outI     <= '0;
      outQ     <= '0;
    end else begin
      pend_q   <= pend_d;
      outValid <= outValid_d;
      outI     <= outI_d;
      outQ     <= outQ_d;
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    regRdData_d = '0;
    if (regRd) begin
      unique case (regAddr)
        OFS_CTRL: regRdData_d = 32'({fieldSel_q, ifMode_q, narrow_q,
                                     sliceAuto_q, agcEn_q, compMode_q});
        OFS_GAIN_IDX: regRdData_d = 32'(gainIdx_q);
        OFS_LIMITS: regRdData_d = 32'({8'(idxMax_q), 8'(idxMin_q)});
        OFS_SLICE: regRdData_d = {29'h0, sliceGain_q};
        OFS_TARGET: regRdData_d = 32'({papr_q, 3'h0, target_q});
        OFS_TBL_ADDR: regRdData_d = 32'(tblAddr_q);
        OFS_TBL_DATA: regRdData_d = table_q[tblAddr_q];
        OFS_STATUS: begin
          regRdData_d[0 +: MSB_W]           = avgMsb;
          regRdData_d[ST_PEAK_POS +: MSB_W] = peakMsb;
          regRdData_d[ST_GAIN_POS +: 3]     = sliceGain_q;
          regRdData_d[ST_IDX_POS +: IDX_W]  = gainIdx_q;
        end
        default: regRdData_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) regRdData <= '0;
    else regRdData <= regRdData_d;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  idx_in_range_a: assert property (
    idxMin_q <= idxMax_q
    |=> gainIdx_q >= $past(idxMin_q) && gainIdx_q <= $past(idxMax_q))
    else $error("gain index outside limits");
  gc_reset_a: assert property (
    gcReset |=> gainIdx_q == $past(idxMax_q) && sliceState_q == SL_SETTLE
    && sliceGain_q == 3'sh0)
    else $error("gain control reset not applied");
  host_idx_a: assert property (
    wrIdx && !gcReset && regWrData[IDX_W-1:0] >= idxMin_q
    && regWrData[IDX_W-1:0] <= idxMax_q
    |=> gainIdx_q == $past(regWrData[IDX_W-1:0]))
    else $error("host gain index write lost");
  wide_gain_a: assert property (
    !narrow_q || ifMode_q == IF_FULL |=> sliceGain_q <= 3'sh0)
    else $error("positive interface gain outside narrowband");
  corr_gain_a: assert property (
    !compMode_q |=> sliceGain_q >= 3'sh0)
    else $error("negative interface gain in correction mode");
  full_pass_a: assert property (
    dgValid_q && ifMode_q == IF_FULL |=> outValid
    && outI[DATA_W-1:0] == $past(dgI_q) && outQ[DATA_W-1:0] == $past(dgQ_q))
    else $error("full resolution data altered");
  chg_flag_a: assert property (
    changed ##1 (dgValid_q && ifMode_q == IF_FULL) |=> outI[CHG_BIT])
    else $error("change bit missing");
  q15_range_a: assert property (
    dgValid_q && ifMode_q == IF_Q15 |=> outI[31:14] == {18{outI[14]}}
    && outQ[31:14] == {18{outQ[14]}})
    else $error("15-bit word out of range");

  fast_attack_c: cover property (sliceAuto_q && peakLvl > tgtS);
  neg_gain_c: cover property (outValid && sliceGain_q < 3'sh0);
  q16_out_c: cover property (outValid && ifMode_q == IF_Q16
                             && sliceGain_q == SLICE_MAX);

endmodule

// >>> hdl/rx_gain_pkg.sv
// package: constants and types of the receive gain and slicer block
package rx_gain_pkg;

  // ****************************************
  // datapath widths
  // ****************************************
  localparam int DATA_W    = 22;
  localparam int WORD_W    = 32;
  localparam int GAIN_W    = 12;
  localparam int GAIN_FRAC = 6;
  localparam int MSB_W     = 5;
  localparam int ATTEN_W   = 8;
  localparam int FIELD_W   = 9;

  // ****************************************
  // register offsets and field positions
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_GAIN_IDX = 8'h04;
  localparam logic [7:0] OFS_LIMITS   = 8'h08;
  localparam logic [7:0] OFS_SLICE    = 8'h0C;
  localparam logic [7:0] OFS_TARGET   = 8'h10;
  localparam logic [7:0] OFS_TBL_ADDR = 8'h14;
  localparam logic [7:0] OFS_TBL_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;

  localparam int CTRL_COMP     = 0;
  localparam int CTRL_AGC      = 1;
  localparam int CTRL_AUTO     = 2;
  localparam int CTRL_NARROW   = 3;
  localparam int CTRL_IFMODE   = 4;
  localparam int CTRL_FIELD    = 6;
  localparam int CTRL_RESET    = 8;
  localparam int LIM_MAX_POS   = 8;
  localparam int TGT_PAPR_POS  = 8;
  localparam int ST_PEAK_POS   = 8;
  localparam int ST_GAIN_POS   = 16;
  localparam int ST_IDX_POS    = 24;
  localparam int TBL_ATTEN_POS = 0;
  localparam int TBL_CORR_POS  = 8;
  localparam int TBL_COMP_POS  = 20;
  localparam int CHG_BIT       = 22;
  localparam int FIELD_POS     = 23;

  // ****************************************
  // reset values and fixed figures
  // ****************************************
  localparam logic [31:0]      TBL_RST    = 32'h0400_4000;
  localparam logic [4:0]       TARGET_RST = 5'h15;
  localparam logic [2:0]       PAPR_RST   = 3'h2;
  localparam logic signed [2:0] SLICE_MAX = 3'sh3;
  localparam logic signed [2:0] SLICE_MIN = 3'sh5;
  localparam logic [3:0]       DROP_Q16   = 4'h9;
  localparam logic [3:0]       DROP_Q15   = 4'hA;
  localparam logic [2:0]       GUARD_BITS = 3'h3;

  typedef enum logic [1:0] {IF_FULL, IF_Q16, IF_Q15} ifmode_type;
  typedef enum logic [1:0] {FLD_ZERO, FLD_IFGAIN, FLD_INDEX} field_type;
  typedef enum logic {SL_SETTLE, SL_TRACK} slice_state_type;

endpackage

// >>> hdl/rx_slicer.sv
// module: bit-shift interface gain, rounding and saturating quantizer
`timescale 1ns/1ns
module rx_slicer
  import rx_gain_pkg::*;
(
  input  wire logic signed [DATA_W-1:0] dataIn,
  input  wire logic signed [2:0]        shift,
  input  wire logic                     q15,
  output logic signed [15:0]            dataOut
);

  logic        [2:0]  sh;
  logic        [3:0]  drop;
  logic signed [28:0] ext;
  logic signed [28:0] rnd;

  // three guard bits keep attenuation shifts lossless until rounding
  always_comb begin
    sh   = shift + GUARD_BITS;
    drop = q15 ? DROP_Q15 : DROP_Q16;
    ext  = 29'(dataIn) <<< sh;
    rnd  = (ext + (29'sh1 <<< (drop - 4'h1))) >>> drop;
    if (q15) begin
      if (rnd > 29'sh3FFF) dataOut = 16'sh3FFF;
      else if (rnd < -29'sh4000) dataOut = 16'shC000;
      else dataOut = 16'(rnd);
    end else begin
      if (rnd > 29'sh7FFF) dataOut = 16'sh7FFF;
      else if (rnd < -29'sh8000) dataOut = 16'sh8000;
      else dataOut = 16'(rnd);
    end
  end

endmodule

// >>> hdl/rx_level_est.sv
// module: signal level estimate (average and peak) ahead of the slicer
`timescale 1ns/1ns
module rx_level_est
  import rx_gain_pkg::*;
#(
  parameter int AVG_SHIFT = 4
)(
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     clear,
  input  wire logic                     valid,
  input  wire logic signed [DATA_W-1:0] dataI,
  input  wire logic signed [DATA_W-1:0] dataQ,
  output logic [MSB_W-1:0]              avgMsb,
  output logic [MSB_W-1:0]              peakMsb
);

  if (AVG_SHIFT < 1 || AVG_SHIFT > 8) $error("AVG_SHIFT out of range");

  logic [DATA_W+AVG_SHIFT-1:0] acc_q, acc_d;
  logic [MSB_W-1:0]            avgMsb_d, peakMsb_d;
  logic [DATA_W-1:0]           magI, magQ, mag;

  function automatic logic [MSB_W-1:0] msbPos(input logic [DATA_W-1:0] v);
    logic [MSB_W-1:0] p;
    p = '0;
    for (int b = 0; b < DATA_W; b++) begin
      if (v[b]) p = MSB_W'(b);
    end
    return p;
  endfunction

  // magnitude as max(|I|,|Q|): cheap and close enough for 6 dB steps
  always_comb begin
    magI      = dataI[DATA_W-1] ? DATA_W'(-dataI) : DATA_W'(dataI);
    magQ      = dataQ[DATA_W-1] ? DATA_W'(-dataQ) : DATA_W'(dataQ);
    mag       = (magI > magQ) ? magI : magQ;
    acc_d     = acc_q;
    avgMsb_d  = avgMsb;
    peakMsb_d = peakMsb;
    if (clear) begin
      acc_d     = '0;
      avgMsb_d  = '0;
      peakMsb_d = '0;
    end else if (valid) begin
      acc_d     = acc_q - (acc_q >> AVG_SHIFT)
                + (DATA_W+AVG_SHIFT)'(mag);
      avgMsb_d  = msbPos(DATA_W'(acc_q >> AVG_SHIFT));
      peakMsb_d = msbPos(mag);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q   <= '0;
      avgMsb  <= '0;
      peakMsb <= '0;
    end else begin
      acc_q   <= acc_d;
      avgMsb  <= avgMsb_d;
      peakMsb <= peakMsb_d;
    end
  end

endmodule

// >>> bench/rx_port_sink.sv
// baseband-side model that reads the receive data port
`timescale 1ns/1ns
module rx_port_sink (
  input  wire logic        core_clk,
  input  wire logic        outValid,
  input  wire logic [31:0] outI,
  input  wire logic [31:0] outQ,
  output logic [31:0]      gotI,
  output logic [31:0]      gotQ,
  output int               gotCnt
);
  // no back-pressure: a word pair is flagged in one cycle only, then held unflagged until the next
  initial begin
    gotCnt = 0;
    forever begin
      @(posedge core_clk);
      if (outValid) begin
        gotI <= outI;
        gotQ <= outQ;
        gotCnt <= gotCnt + 1;
      end
    end
  end
endmodule

// >>> bench/tb_rx_digital_gain_and_slicer.sv
// self-checking bench for the receive gain and slicer block
`timescale 1ns/1ns
module tb_rx_digital_gain_and_slicer;
  import rx_gain_pkg::*;
  logic                     core_clk, resetn, regWr, regRd, inValid;
  logic                     agcGainDec, agcGainInc, outValid;
  logic [7:0]               regAddr, attenSetting;
  logic [31:0]              regWrData, regRdData, outI, outQ, gotI, gotQ, d;
  logic signed [DATA_W-1:0] inI, inQ;
  int                       gotCnt, err_total, compares;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h20};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h3F00, 32'h0215,
                          32'h0400_4000, 32'h0};
  // ctrl, host slicer gain, input, expected word
  logic [31:0] qt [8][4] = '{'{32'h18, 32'h0, 32'h20, 32'h1},
    '{32'h18, 32'h2, 32'h1000, 32'h100}, '{32'h28, 32'h0, 32'h1000, 32'h20},
    '{32'h18, 32'h3, 32'h1F_FFFF, 32'h7FFF},
    '{32'h18, 32'h3, 32'h20_0000, 32'hFFFF_8000},
    '{32'h10, 32'h2, 32'h1000, 32'h40}, '{32'h11, 32'h7, 32'h1000, 32'h20},
    '{32'h10, 32'h7, 32'h1000, 32'h40}};

  rx_digital_gain_and_slicer #(.UPDATE_SAMPLES(4), .AVG_SHIFT(1)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .inValid(inValid), .inI(inI), .inQ(inQ),
    .agcGainDec(agcGainDec), .agcGainInc(agcGainInc),
    .attenSetting(attenSetting), .outValid(outValid), .outI(outI),
    .outQ(outQ));
  rx_port_sink u_sink (.core_clk(core_clk), .outValid(outValid),
    .outI(outI), .outQ(outQ), .gotI(gotI), .gotQ(gotQ), .gotCnt(gotCnt));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic give_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  // one sample in, bounded wait for its word pair at the sink
  task automatic smp(input logic [21:0] i, input logic [21:0] q);
    int n;
    n = gotCnt;
    @(posedge core_clk);
    inI <= i;
    inQ <= q;
    inValid <= 1'b1;
    @(posedge core_clk);
    inValid <= 1'b0;
    for (int k = 0; k < 8 && gotCnt == n; k++) @(posedge core_clk);
    #1;
    if (gotCnt == n) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic agc(input logic dn, input int cnt);
    repeat (cnt) begin
      @(posedge core_clk);
      agcGainDec <= dn;
      agcGainInc <= !dn;
      @(posedge core_clk);
      agcGainDec <= 1'b0;
      agcGainInc <= 1'b0;
    end
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {resetn, regWr, regRd, inValid, agcGainDec, agcGainInc} = '0;
    {regAddr, regWrData, inI, inQ} = '0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (ra[k]) begin
      rd(ra[k], d);
      chk(d, rv[k]);
    end
    wr(OFS_TBL_ADDR, 32'h3);
    wr(OFS_TBL_DATA, 32'h1000_8005);
    wr(OFS_CTRL, 32'h80);
    smp(22'h1000, 22'h0);
    chk(gotI, 32'h0000_1000);
    wr(OFS_GAIN_IDX, 32'h3);
    smp(22'h1000, 22'h0);
    chk(gotI, 32'h01C0_2000);
    chk({24'h0, attenSetting}, 32'h5);
    smp(22'h1000, 22'h0);
    chk(gotI, 32'h0180_2000);
    wr(OFS_CTRL, 32'h81);
    smp(22'h1000, 22'h0);
    chk(gotI, 32'h0180_4000);
    smp(22'h10_0000, 22'h30_0000);
    chk({10'h0, gotI[21:0]}, 32'h1F_FFFF);
    chk({10'h0, gotQ[21:0]}, 32'h20_0000);
    wr(OFS_GAIN_IDX, 32'h0);
    foreach (qt[k]) begin
      wr(OFS_CTRL, qt[k][0]);
      wr(OFS_SLICE, qt[k][1]);
      smp(qt[k][2][21:0], 22'h0);
      chk(gotI, qt[k][3]);
    end
    wr(OFS_CTRL, 32'h41);
    smp(22'h1000, 22'h0);
    chk(gotI, 32'hFFC0_1000);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_LIMITS, 32'h0502);
    wr(OFS_GAIN_IDX, 32'h9);
    rd(OFS_GAIN_IDX, d);
    chk(d, 32'h5);
    agc(1'b1, 4);
    rd(OFS_GAIN_IDX, d);
    chk(d, 32'h2);
    agc(1'b0, 5);
    agc(1'b1, 1);
    rd(OFS_GAIN_IDX, d);
    chk(d, 32'h4);
    wr(OFS_CTRL, 32'h100);
    rd(OFS_GAIN_IDX, d);
    chk(d, 32'h5);
    wr(OFS_TARGET, 32'h0215);
    wr(OFS_CTRL, 32'h11C);
    repeat (12) smp(22'h100, 22'h100);
    rd(OFS_STATUS, d);
    chk({29'h0, d[18:16]}, 32'h3);
    repeat (3) smp(22'h1F_FFFF, 22'h1F_FFFF);
    rd(OFS_STATUS, d);
    chk({31'h0, d[18:16] < 3'h2}, 32'h1);
    give_verdict();
  end
endmodule
